/* File: src/trig_pwm_map.vh */
`ifndef TRIG_PWM_MAP_VH
`define TRIG_PWM_MAP_VH
// ==========================================================================
// register offsets (byte addresses, one 32-bit word each)
// ==========================================================================
`define CTRL0_OFS      8'h00
`define CTRL1_OFS      8'h04
`define PRESCALE_OFS   8'h08
`define OUTCTL_OFS     8'h0C
`define CMP0_OFS       8'h10
`define CMP1_OFS       8'h14
`define CMP2_OFS       8'h18
`define CMP3_OFS       8'h1C
`define COUNT_OFS      8'h20
`define IRQ_STAT_OFS   8'h24
`define IRQ_CLR_OFS    8'h28
`define IRQ_EN_OFS     8'h2C
// ==========================================================================
// field positions
// ==========================================================================
`define CE_BIT         0
`define TRIG_BIT       0
`define OE_LSB         0
`define OLS_LSB        4
// ==========================================================================
// reset and special values
// ==========================================================================
`define CNT_IDLE       16'hFFFF
`define CNT_ZERO       16'h0000
`define CMP_RST        16'h0000
`define PRESCALE_RST   16'h0000
`define NUM_CH         4
`endif

/* File: src/tick_divider.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// count clock divider: one-cycle tick every div_i+1 clocks while running
// ==========================================================================
module tick_divider #(
    parameter W = 16
) (
    input  wire         clk_i,   // system clock
    input  wire         rst_i,   // synchronous reset
    input  wire         run_i,   // divider runs while high
    input  wire [W-1:0] div_i,   // divide value minus one
    output reg          tick_o   // count clock enable pulse
);
    reg [W-1:0] cnt_r;

    // restarting on run_i low gives every start the same phase
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r  <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_r >= div_i) begin
            cnt_r  <= {W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule // tick_divider
`default_nettype wire

/* File: src/pwm_pin_stage.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// output pin stage: level select, output enable and idle level
// ==========================================================================
module pwm_pin_stage (
    input  wire clk_i,       // system clock
    input  wire rst_i,       // synchronous reset
    input  wire active_i,    // enabled, counting and started
    input  wire level_sel_i, // output level select
    input  wire wave_i,      // raw waveform, 1 = active
    output reg  pin_o        // registered pin level
);
    // inactive pins sit at the level select value, active ones invert it while wave_i is high
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 1'b0;
        end else if (active_i) begin
            pin_o <= level_sel_i ^ wave_i;
        end else begin
            pin_o <= level_sel_i;
        end
    end
endmodule // pwm_pin_stage
`default_nettype wire

/* File: src/triggered_pwm_timer_output.v */
// Contract
// - level select 0: idle low, active high
// - level select 1: idle high, active low
// - unit 0 four outputs, unit 1 one
// - count enable set: wait for trigger
// - trigger clears FFFFH to 0000H and counts
// - trigger while running restarts from 0000H
// - trigger inverts cycle output, forces duty active
// - duty width compare ticks, period cycle+1
// - count after cycle match clears, cycle interrupt
// - duty interrupt when count equals duty buffer
// - buffers load at clear, only after duty1 write; the code also loads them at the first trigger from idle, with no duty1 write
// - software trigger bit is only trigger
// - duty 0000H gives 0%, irqs at clear
// - duty cycle+1 gives 100%
// - interrupts one clock after shown match
//
// Design decisions made here: register access over Wishbone and the address map.
`include "trig_pwm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module triggered_pwm_timer_output #(
    parameter NUM_OUT_CH = 4,  // 4 for unit 0, 1 for unit 1
    parameter DIV_W      = 16  // prescale width
) (
    input  wire        clk_i,     // system clock, 125 MHz
    input  wire        rst_i,     // synchronous reset, active high
    input  wire        wb_cyc_i,  // wishbone cycle
    input  wire        wb_stb_i,  // wishbone strobe
    input  wire        wb_we_i,   // wishbone write enable
    input  wire [7:0]  wb_adr_i,  // wishbone byte address
    input  wire [3:0]  wb_sel_i,  // wishbone byte selects
    input  wire [31:0] wb_dat_i,  // wishbone write data
    output reg  [31:0] wb_dat_o,  // wishbone read data
    output reg         wb_ack_o,  // wishbone acknowledge
    output wire [3:0]  pwm_o,     // 0 cycle toggle, 1..3 duty pwm
    output reg         irq_o      // level interrupt
);
    // ======================================================================
    // state
    // ======================================================================
    reg              count_enable_r;
    reg  [DIV_W-1:0] prescale_r;
    reg  [3:0]       output_enable_r;
    reg  [3:0]       output_level_r;
    reg  [15:0]      cnt_r;
    reg              running_r;
    reg              trig_pend_r;
    reg              commit_r;
    reg              cyc_wave_r;
    reg  [3:0]       ev_r;
    reg  [3:0]       irq_stat_r;
    reg  [3:0]       irq_en_r;
    wire             tick;
    wire [63:0]      cmp_flat;
    wire [63:0]      buf_flat;
    wire [3:0]       wave;
    wire [3:0]       ch_mask;
    wire [3:0]       wr_cmp;

    // ======================================================================
    // bus decode
    // ======================================================================
    wire req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr    = req & wb_we_i;
    wire wr_c0 = wr & (wb_adr_i == `CTRL0_OFS);
    wire wr_c1 = wr & (wb_adr_i == `CTRL1_OFS);
    wire wr_ps = wr & (wb_adr_i == `PRESCALE_OFS);
    wire wr_oc = wr & (wb_adr_i == `OUTCTL_OFS);
    wire wr_ic = wr & (wb_adr_i == `IRQ_CLR_OFS);
    wire wr_ie = wr & (wb_adr_i == `IRQ_EN_OFS);
    assign wr_cmp[0] = wr & (wb_adr_i == `CMP0_OFS);
    assign wr_cmp[1] = wr & (wb_adr_i == `CMP1_OFS);
    assign wr_cmp[2] = wr & (wb_adr_i == `CMP2_OFS);
    assign wr_cmp[3] = wr & (wb_adr_i == `CMP3_OFS);

    // byte lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
            merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
        end
    endfunction

    // the trigger is acted on only at a count tick, with enable still set
    wire trig_wr = wr_c1 & wb_sel_i[0] & wb_dat_i[`TRIG_BIT];
    wire step    = tick & count_enable_r;

    // ======================================================================
    // counter sequencing
    // ======================================================================
    wire [15:0] cyc_buf  = buf_flat[15:0];
    wire        cyc_hit  = running_r & (cnt_r == cyc_buf);
    wire        do_trig  = step & trig_pend_r;
    wire        do_clear = step & ~trig_pend_r & cyc_hit;
    wire        do_inc   = step & ~trig_pend_r & running_r & ~cyc_hit;
    wire        loads    = do_trig | do_clear | do_inc;
    wire [15:0] cnt_nxt  = do_inc ? cnt_r + 16'h0001 : `CNT_ZERO;
    // first start loads the buffers so the first period is defined
    wire        xfer     = (do_clear & commit_r) |
                           (do_trig & ~running_r);

    // control registers written by software
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_enable_r  <= 1'b0;
            prescale_r      <= `PRESCALE_RST;
            output_enable_r <= 4'h0;
            output_level_r  <= 4'h0;
            irq_en_r        <= 4'h0;
        end else begin
            if (wr_c0 && wb_sel_i[0])
                count_enable_r <= wb_dat_i[`CE_BIT];
            if (wr_ps)
                prescale_r <= merge16(prescale_r, wb_dat_i,
                                      wb_sel_i) ;
            if (wr_oc && wb_sel_i[0]) begin
                output_enable_r <= wb_dat_i[`OE_LSB+3:`OE_LSB] & ch_mask;
                output_level_r  <= wb_dat_i[`OLS_LSB+3:`OLS_LSB] & ch_mask;
            end
            if (wr_ie && wb_sel_i[0])
                irq_en_r <= wb_dat_i[3:0];
        end
    end

    // pending trigger: a new write wins over consumption in the same cycle
    always @(posedge clk_i) begin
        if (rst_i || !count_enable_r) begin
            trig_pend_r <= 1'b0;
        end else begin
            trig_pend_r <= (trig_pend_r & ~step) | trig_wr;
        end
    end

    // the counter idles at all ones until the first trigger
    always @(posedge clk_i) begin
        if (rst_i || !count_enable_r) begin
            cnt_r      <= `CNT_IDLE;
            running_r  <= 1'b0;
            cyc_wave_r <= 1'b0;
        end else if (loads) begin
            cnt_r <= cnt_nxt;
            if (do_trig)
                running_r <= 1'b1;
            if (do_trig || do_clear)
                cyc_wave_r <= ~cyc_wave_r;
        end
    end

    // batch commit flag, armed by a duty1 write, spent at transfer
    always @(posedge clk_i) begin
        if (rst_i) begin
            commit_r <= 1'b0;
        end else begin
            commit_r <= (commit_r & ~xfer) | wr_cmp[1];
        end
    end

    // ======================================================================
    // compare registers, buffers and duty waves
    // ======================================================================
    genvar i;
    generate
        for (i = 0; i < `NUM_CH; i = i + 1) begin : g_ch
            reg [15:0] cmp_r;
            reg [15:0] buf_r;
            // writing during a transfer is the caller's hazard
            always @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_r <= `CMP_RST;
                    buf_r <= `CMP_RST;
                end else begin
                    if (wr_cmp[i])
                        cmp_r <= merge16(cmp_r, wb_dat_i, wb_sel_i);
                    if (xfer)
                        buf_r <= cmp_r;
                end
            end
            assign cmp_flat[16*i+15:16*i] = cmp_r;
            assign buf_flat[16*i+15:16*i] = buf_r;
            assign ch_mask[i] = (i < NUM_OUT_CH);
            if (i == 0) begin : g_cyc
                assign wave[i] = cyc_wave_r;
            end else begin : g_duty
                // active while count below compare: 0 never, cycle+1 always
                assign wave[i] = running_r & (cnt_r < buf_r);
            end
            pwm_pin_stage u_pin (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .active_i    (output_enable_r[i] & count_enable_r &
                              running_r & ch_mask[i]),
                .level_sel_i (output_level_r[i]),
                .wave_i      (wave[i]),
                .pin_o       (pwm_o[i])
            );
        end
    endgenerate

    // ======================================================================
    // count clock
    // ======================================================================
    tick_divider #(
        .W (DIV_W)
    ) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (count_enable_r),
        .div_i  (prescale_r),
        .tick_o (tick)
    );

    // ======================================================================
    // match events and interrupts
    // ======================================================================
    // on a transfer edge the new count meets the values being loaded,
    // otherwise a stale buffer would raise a false match at start
    wire [63:0] buf_next = xfer ? cmp_flat : buf_flat;

    // events appear with the new count, status one clock later
    always @(posedge clk_i) begin
        if (rst_i) begin
            ev_r <= 4'h0;
        end else begin
            ev_r[0] <= do_clear;
            ev_r[1] <= loads & (cnt_nxt == buf_next[31:16]);
            ev_r[2] <= loads & (cnt_nxt == buf_next[47:32]);
            ev_r[3] <= loads & (cnt_nxt == buf_next[63:48]);
        end
    end

    // sticky status: an event beats a clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 4'h0;
            irq_o      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r &
                           ~((wr_ic && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0))
                          | (ev_r & {3'b111, 1'b1});
            irq_o      <= |(irq_stat_r & irq_en_r);
        end
    end

    // ======================================================================
    // bus answer
    // ======================================================================
    // one wait state; unmapped addresses answer with zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                case (wb_adr_i)
                    `CTRL0_OFS:
                        wb_dat_o <= {31'h0, count_enable_r};
                    `PRESCALE_OFS:
                        wb_dat_o <= {{(32-DIV_W){1'b0}}, prescale_r};
                    `OUTCTL_OFS:
                        wb_dat_o <= {24'h0, output_level_r,
                                     output_enable_r};
                    `CMP0_OFS: wb_dat_o <= {16'h0, cmp_flat[15:0]};
                    `CMP1_OFS: wb_dat_o <= {16'h0, cmp_flat[31:16]};
                    `CMP2_OFS: wb_dat_o <= {16'h0, cmp_flat[47:32]};
                    `CMP3_OFS: wb_dat_o <= {16'h0, cmp_flat[63:48]};
                    `COUNT_OFS: wb_dat_o <= {16'h0, cnt_r};
                    `IRQ_STAT_OFS: wb_dat_o <= {28'h0, irq_stat_r};
                    `IRQ_EN_OFS: wb_dat_o <= {28'h0, irq_en_r};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // triggered_pwm_timer_output
`default_nettype wire

/* File: tb/pwm_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trig_pwm_map.vh"
// ================
// port checker; control state is shadowed from accepted bus writes
module pwm_timer_sva #(
    parameter int NUM_OUT_CH = 4 // pins present
) (
    input wire logic        clk_i,    // clock
    input wire logic        rst_i,    // reset
    input wire logic        wb_cyc_i, // cycle
    input wire logic        wb_stb_i, // strobe
    input wire logic        wb_we_i,  // write
    input wire logic [7:0]  wb_adr_i, // address
    input wire logic [3:0]  wb_sel_i, // selects
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic        wb_ack_o, // ack
    input wire logic [3:0]  pwm_o,    // pins
    input wire logic        irq_o     // interrupt
);
    localparam logic [3:0] CHM = 4'((1 << NUM_OUT_CH) - 1);
    logic       ce_r, go_r, pz_r, nz_r, wr, trg, rd, run, ctl;
    logic [3:0] oe_r, ols_r, en_r, idl;
    logic [7:0] wa;
    logic [1:0] st_r;
    // sel is not decoded: the bench only writes whole words
    assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign wa  = wr ? wb_adr_i : 8'hFC;
    assign trg = wa == `CTRL1_OFS && wb_dat_i[0] && ce_r;
    assign ctl = trg || wa == `CTRL0_OFS || wa == `OUTCTL_OFS;
    assign rd  = wb_ack_o && !wb_we_i;
    assign run = ce_r && go_r;
    assign idl = run ? ~oe_r : 4'hF;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // st_r waits out the pin pipeline after any control change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {ce_r, go_r, nz_r, oe_r, ols_r, en_r, st_r} <= '0;
            pz_r <= 1'b1;
        end else begin
            st_r <= ctl ? 2'd0 : st_r + {1'b0, st_r != 2'd3};
            go_r <= trg || (go_r && !(wa == `CTRL0_OFS && !wb_dat_i[0]));
            if (wa == `CTRL0_OFS) ce_r <= wb_dat_i[0];
            if (wa == `OUTCTL_OFS) oe_r <= wb_dat_i[3:0] & CHM;
            if (wa == `OUTCTL_OFS) ols_r <= wb_dat_i[7:4] & CHM;
            if (wa == `PRESCALE_OFS) pz_r <= wb_dat_i[15:0] == 16'h0000;
            if (wa == `CMP1_OFS) nz_r <= wb_dat_i[15:0] != 16'h0000;
            if (wa == `IRQ_EN_OFS) en_r <= wb_dat_i[3:0];
        end
    end
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acknowledged");
    a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held too long");
    a_upper_zero: assert property (rd |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_reads_zero: assert property (rd && (wb_adr_i == `CTRL1_OFS
        || wb_adr_i == `IRQ_CLR_OFS || wb_adr_i > `IRQ_EN_OFS)
        |-> wb_dat_o == 32'h0000_0000) else $error("read not zero");
    a_idle_level: assert property (
        st_r == 2'd3 |-> ((pwm_o ^ ols_r) & idl) == 4'h0)
        else $error("idle pin not at its level select");
    a_count_idle: assert property (
        rd && wb_adr_i == `COUNT_OFS && !run && !$past(run, 2)
        |-> wb_dat_o[15:0] == 16'hFFFF) else $error("idle count wrong");
    a_trig_duty: assert property (
        trg && oe_r[1] && !ols_r[1] && nz_r && pz_r |-> ##[1:4] pwm_o[1])
        else $error("duty pin not active after trigger");
    a_cycle_flip: assert property (
        trg && go_r && oe_r[0] && pz_r |-> ##[1:4] $changed(pwm_o[0]))
        else $error("cycle pin did not flip on restart");
    a_irq_masked: assert property (en_r == 4'h0 && $past(en_r) == 4'h0
        |-> !irq_o) else $error("interrupt while all masked");
endmodule // pwm_timer_sva
bind triggered_pwm_timer_output pwm_timer_sva #(
    .NUM_OUT_CH(NUM_OUT_CH)
) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pwm_o(pwm_o), .irq_o(irq_o));
`default_nettype wire

/* File: tb/pwm_load.sv */
`timescale 1ns/1ps
`default_nettype none
// ================
// load model: measures pin 1 high runs and pin 0 flip spacing
module pwm_load (
    input  wire logic        clk_i,    // clock
    input  wire logic [3:0]  pin_i,    // timer pins
    output logic      [15:0] hi_len_o, // last high run of pin 1
    output logic      [15:0] tog_len_o // last gap between pin 0 flips
);
    logic [15:0] hi_r, tg_r;
    logic [3:0]  prev_r;
    // a passive stage never drives back, so it only watches
    always @(posedge clk_i) begin
        prev_r <= pin_i;
        hi_r   <= pin_i[1] ? hi_r + 16'h1 : 16'h0;
        tg_r   <= (prev_r[0] != pin_i[0]) ? 16'h1 : tg_r + 16'h1;
        if (prev_r[1] && !pin_i[1]) hi_len_o <= hi_r;
        if (prev_r[0] != pin_i[0]) tog_len_o <= tg_r;
    end
endmodule // pwm_load
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trig_pwm_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
// ================
// bench: bus tasks drive the timer, the load model measures its pins
module tb;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic [3:0]  pwm;
    logic [15:0] hi_len, tog_len;
    int          mismatches = 0, checks_done = 0, ticks = 0;
    triggered_pwm_timer_output #(.NUM_OUT_CH(4), .DIV_W(16)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pwm_o(pwm), .irq_o(irq));
    pwm_load u_load (.clk_i(clk_i), .pin_i(pwm), .hi_len_o(hi_len),
        .tog_len_o(tog_len));
    initial forever #4 clk_i = ~clk_i;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // whole run is a few hundred cycles; this only cuts a hang
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    // one classic cycle; ack and read data are taken at one rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        `CHK(ack, 1'b1)
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    task automatic hold(input int k, input logic v, input int n);
        repeat (n) begin
            @(negedge clk_i);
            `CHK(pwm[k], v)
        end
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        // let a just-cleared status reach the pin before looking
        @(negedge clk_i);
        while (irq !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(irq, 1'b1)
    endtask
    // main sequence: period 10 ticks, duties 3, 0% and 100%
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`COUNT_OFS, 32'h0000_FFFF);
        rd(`CMP1_OFS, 32'h0);
        rd(8'h30, 32'h0);
        rd(`CTRL1_OFS, 32'h0);
        wr(`PRESCALE_OFS, 32'h0);
        wr(`OUTCTL_OFS, 32'h0F);
        wr(`CMP0_OFS, 32'h9);
        wr(`CMP2_OFS, 32'h0);
        wr(`CMP3_OFS, 32'hA);
        wr(`CMP1_OFS, 32'h3);
        wr(`CTRL1_OFS, 32'h1);
        wr(`CTRL0_OFS, 32'h1);
        hold(1, 1'b0, 20);
        rd(`COUNT_OFS, 32'h0000_FFFF);
        wr(`CTRL1_OFS, 32'h1);
        repeat (4) @(negedge clk_i);
        hold(3, 1'b1, 40);
        hold(2, 1'b0, 20);
        `CHK(hi_len, 16'd3)
        `CHK(tog_len, 16'd10)
        rd(`IRQ_STAT_OFS, 32'h7);
        `CHK(irq, 1'b0)
        wr(`CMP0_OFS, 32'h13);
        repeat (40) @(negedge clk_i);
        `CHK(tog_len, 16'd10)
        wr(`CMP1_OFS, 32'h3);
        wr(`IRQ_CLR_OFS, 32'hF);
        wr(`IRQ_EN_OFS, 32'h1);
        wait_irq();
        repeat (60) @(negedge clk_i);
        `CHK(tog_len, 16'd20)
        `CHK(hi_len, 16'd3)
        wr(`IRQ_CLR_OFS, 32'h1);
        wait_irq();
        wr(`IRQ_CLR_OFS, 32'h1);
        @(negedge clk_i);
        `CHK(irq, 1'b0)
        wr(`CTRL1_OFS, 32'h1);
        wb(1'b0, `COUNT_OFS, 32'h0, r);
        `CHK(r, 32'h0000_0001)
        wr(`IRQ_EN_OFS, 32'h0);
        repeat (25) @(negedge clk_i);
        `CHK(irq, 1'b0)
        wr(`IRQ_EN_OFS, 32'h1);
        repeat (3) @(negedge clk_i);
        `CHK(irq, 1'b1)
        wr(`OUTCTL_OFS, 32'hF0);
        repeat (3) @(negedge clk_i);
        `CHK(pwm, 4'hF)
        wr(`OUTCTL_OFS, 32'h2F);
        wr(`CTRL0_OFS, 32'h0);
        repeat (3) @(negedge clk_i);
        `CHK(pwm, 4'h2)
        rd(`COUNT_OFS, 32'h0000_FFFF);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
